//--- scs_map.svh
// Register map, field positions, reset values and timing figures of the sync selector
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// Register byte addresses
`define SCS_ADDR_CTRL 12'h000
`define SCS_ADDR_STATUS 12'h004
`define SCS_ADDR_IRQ_STAT 12'h008
`define SCS_ADDR_IRQ_MASK 12'h00C
`define SCS_ADDR_PERIOD 12'h010

// Control register fields
`define SCS_CTRL_W 15
`define SCS_CTRL_RST 15'h0000
`define SCS_CTRL_RATE 2:0
`define SCS_CTRL_SYNC 4:3
`define SCS_CTRL_SA 5
`define SCS_CTRL_WCM 7:6
`define SCS_CTRL_CONV 9:8
`define SCS_CTRL_ORATE 12:10
`define SCS_CTRL_OSYNC 14:13

// Interrupt status bits
`define SCS_IRQ_W 4
`define SCS_IRQ_LOCK 0
`define SCS_IRQ_FALLBACK 1
`define SCS_IRQ_RATE_CHG 2
`define SCS_IRQ_OUT_LOST 3

// Clock and sample rates in hertz, plus the system clock in kilohertz
`define SCS_CLK_HZ 28'hBEB_C200
`define SCS_CLK_KHZ 32'h3_0D40
`define SCS_RATE0_HZ 28'hAC44
`define SCS_RATE1_HZ 28'hBB80
`define SCS_RATE2_HZ 28'h1_5888
`define SCS_RATE3_HZ 28'h1_7700
`define SCS_RATE4_HZ 28'h2_B110
`define SCS_RATE5_HZ 28'h2_EE00
`define SCS_RATE_NUM 6
`define SCS_WC_SUPER_SHIFT 9
`define SCS_WC_PLAIN_SHIFT 1

// Qualification of an external reference
`define SCS_TOL_SHIFT 6
`define SCS_QUAL_CNT 8
`define SCS_MEAS_W 16

// Times in their own units
`define SCS_BLINK_MS 32'hFA
`define SCS_TIMEOUT_US 32'h32

`endif

//--- scs_period_meter.sv
// Period meter: counts system clocks between reference edges
`timescale 1ns/100ps
module scs_period_meter #(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned TIMEOUT = 10000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Reference events
    input wire logic edge_pulse,
    input wire logic restart,
    // Measurement
    output logic [CNT_W-1:0] period,
    output logic period_new,
    output logic absent
);
    // Whole meter state
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] per;
        logic nw;
        logic abs;
    } scs_meter_t;

    scs_meter_t r_reg;
    scs_meter_t r_next;

    // Next-state logic
    always_comb
    begin
        r_next = r_reg;
        r_next.nw = 1'b0;
        if (restart)
        begin
            // Discard the partial period after a reselection
            r_next.cnt = '0;
            r_next.abs = 1'b1;
        end
        else if (edge_pulse)
        begin
            // First edge after absence only starts a period
            r_next.per = r_reg.cnt;
            r_next.nw = !r_reg.abs;
            r_next.abs = 1'b0;
            r_next.cnt = CNT_W'(1);
        end
        else if (r_reg.cnt >= CNT_W'(TIMEOUT - 1))
        begin
            // No edge for too long: reference absent
            r_next.abs = 1'b1;
        end
        else
        begin
            r_next.cnt = r_reg.cnt + CNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            r_reg <= '{cnt: '0, per: '0, nw: 1'b0, abs: 1'b1};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign period = r_reg.per;
    assign period_new = r_reg.nw;
    assign absent = r_reg.abs;
endmodule

//--- scs_pkg.sv
// Types shared by the sync selector modules
package scs_pkg;
    // Clocking state, one-hot
    typedef enum logic [2:0] {
        SCS_ST_MASTER = 3'h1,
        SCS_ST_SLAVE = 3'h2,
        SCS_ST_FALLBACK = 3'h4
    } scs_state_t;
    // Sync source choice
    typedef enum logic [1:0] {
        SCS_SRC_LOCAL = 2'h0,
        SCS_SRC_WCLK = 2'h1,
        SCS_SRC_DIGIN = 2'h2,
        SCS_SRC_OPTIC = 2'h3
    } scs_src_t;
    // Word clock output mode
    typedef enum logic [1:0] {
        SCS_WCM_RATE = 2'h0,
        SCS_WCM_X256 = 2'h1,
        SCS_WCM_BASE = 2'h2
    } scs_wcm_t;
    // Converter placement
    typedef enum logic [1:0] {
        SCS_CONV_NONE = 2'h0,
        SCS_CONV_IN = 2'h1,
        SCS_CONV_OUT = 2'h2
    } scs_conv_t;
endpackage

//--- scs_ref_src.sv
// Behavioural external reference clock for the sync selector bench
`timescale 1ns/100ps
module scs_ref_src (
    // Bench control
    input wire logic run,
    input wire logic [15:0] period,
    // Reference line, idle low
    output logic ref_clk
);
    // Square wave, period in system clocks, phase unrelated; low while absent
    always
    begin
        if (run)
        begin
            ref_clk = 1'b1;
            #(period * 2.5);
            ref_clk = 1'b0;
            #(period * 2.5);
        end
        else
        begin
            ref_clk = 1'b0;
            #1.3;
        end
    end
endmodule

//--- scs_sync_top.sv
// Sample clock source selection, fallback and word clock output
// Notes on behaviour
// RL1 - Sample clock always made internally, never host
// RL2 - Local reference: master, indicator steadily on
// RL3 - Locked to external source: slave, indicator off
// RL4 - Bad external source: local rate, indicator flashes
// RL5 - Audio re-enabled when reference returns correctly
// RL6 - Stand-alone: rate follows valid sync source
// RL7 - All channels share one rate and source
// RL8 - Input converter accepts digital input any rate
// RL9 - Output converter: own rate, lockable to reference
// RL10 - Word clock out: sample rate or 256x
// RL11 - Base clock: 44.1k or 48k by family
// RL12 - Sync choices local, digital input, word clock; the main selection here also offers optical
// RL13 - Reference measured against rate, requalified continuously
`timescale 1ns/100ps
`include "scs_map.svh"
module scs_sync_top #(
    parameter int unsigned BLINK_CYC = `SCS_BLINK_MS * `SCS_CLK_KHZ,
    parameter int unsigned TIMEOUT_CYC = `SCS_TIMEOUT_US * (`SCS_CLK_KHZ / 1000),
    parameter int unsigned QUAL = `SCS_QUAL_CNT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External references
    input wire logic wordclock_in,
    input wire logic digital_input_sync,
    input wire logic optical_sync_in,
    // Clock outputs
    output logic sample_tick,
    output logic out_sample_tick,
    output logic wordclock_out,
    // Status
    output logic master_led,
    output logic audio_enable,
    output logic src_in_active,
    output logic src_out_active,
    output logic irq
);
    import scs_pkg::*;

    localparam int unsigned BW = $clog2(BLINK_CYC + 1);
    localparam int unsigned MW = `SCS_MEAS_W;

    // Whole block state
    typedef struct packed {
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic [2:0] sy3;
        logic [`SCS_CTRL_W-1:0] ctrl;
        logic [`SCS_IRQ_W-1:0] istat;
        logic [`SCS_IRQ_W-1:0] imask;
        scs_state_t st;
        logic [2:0] act_rate;
        logic [3:0] qual;
        logic [3:0] oqual;
        logic olock;
        logic [27:0] nacc;
        logic [27:0] oacc;
        logic [27:0] wacc;
        logic tick;
        logic otick;
        logic wclk;
        logic [BW-1:0] bcnt;
        logic blink;
        logic led;
        logic aen;
        logic sin;
        logic sout;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } scs_top_t;

    scs_top_t r;
    scs_top_t n;

    // Meter results and control decode
    logic [MW-1:0] meas_per;
    logic meas_new;
    logic meas_absent;
    logic [MW-1:0] omeas_per;
    logic omeas_new;
    logic omeas_absent;
    logic [2:0] edges;
    logic sel_edge;
    logic out_edge;
    logic wr_ctrl;
    scs_src_t sync_sel;
    scs_src_t osync_sel;
    logic [2:0] ctrl_rate;

    // Rate code to hertz; codes 6 and 7 read as 48 kHz
    function automatic logic [27:0] rate_hz(input logic [2:0] c);
        case (c)
            3'h0: return `SCS_RATE0_HZ;
            3'h2: return `SCS_RATE2_HZ;
            3'h3: return `SCS_RATE3_HZ;
            3'h4: return `SCS_RATE4_HZ;
            3'h5: return `SCS_RATE5_HZ;
            default: return `SCS_RATE1_HZ;
        endcase
    endfunction

    // Measured period against nominal, within tolerance
    function automatic logic match(input logic [MW-1:0] m, input logic [2:0] c);
        logic [MW-1:0] nom;
        logic [MW-1:0] d;
        nom = MW'(`SCS_CLK_HZ / rate_hz(c));
        d = (m > nom) ? m - nom : nom - m;
        return d <= (nom >> `SCS_TOL_SHIFT);
    endfunction

    // Fractional divider step: wrap flag and new phase
    function automatic logic [28:0] nco(input logic [27:0] a, input logic [27:0] s);
        logic [28:0] sum;
        sum = {1'b0, a} + {1'b0, s};
        if (sum >= {1'b0, `SCS_CLK_HZ})
        begin
            return {1'b1, 28'(sum - {1'b0, `SCS_CLK_HZ})};
        end
        return {1'b0, sum[27:0]};
    endfunction

    assign sync_sel = scs_src_t'(r.ctrl[`SCS_CTRL_SYNC]);
    assign osync_sel = scs_src_t'(r.ctrl[`SCS_CTRL_OSYNC]);
    assign ctrl_rate = r.ctrl[`SCS_CTRL_RATE];
    assign edges = r.sy2 & ~r.sy3;
    assign wr_ctrl = psel && penable && r.pready && pwrite && paddr == `SCS_ADDR_CTRL;

    // Edge of the chosen main reference
    always_comb
    begin
        case (sync_sel)
            SCS_SRC_WCLK: sel_edge = edges[0];
            SCS_SRC_DIGIN: sel_edge = edges[1];
            SCS_SRC_OPTIC: sel_edge = edges[2];
            default: sel_edge = 1'b0;
        endcase
    end

    // Edge of the converted-output reference; optical is not offered there
    always_comb
    begin
        case (osync_sel)
            SCS_SRC_WCLK: out_edge = edges[0]; // RL12
            SCS_SRC_DIGIN: out_edge = edges[1]; // RL12
            default: out_edge = 1'b0;
        endcase
    end

    // Main reference meter
    scs_period_meter #(.CNT_W(MW), .TIMEOUT(TIMEOUT_CYC)) u_meas (
        .sys_clk(sys_clk),
        .rst(rst),
        .edge_pulse(sel_edge),
        .restart(wr_ctrl),
        .period(meas_per),
        .period_new(meas_new),
        .absent(meas_absent)
    );

    // Converted-output reference meter
    scs_period_meter #(.CNT_W(MW), .TIMEOUT(TIMEOUT_CYC)) u_omeas (
        .sys_clk(sys_clk),
        .rst(rst),
        .edge_pulse(out_edge),
        .restart(wr_ctrl),
        .period(omeas_per),
        .period_new(omeas_new),
        .absent(omeas_absent)
    );

    // Next-state logic for the whole block
    always_comb
    begin
        logic [`SCS_IRQ_W-1:0] set;
        logic [`SCS_IRQ_W-1:0] clr;
        logic det_ok;
        logic [2:0] det_code;
        logic [2:0] tgt;
        logic good;
        logic [28:0] nv;
        logic [28:0] ov;
        logic [28:0] wv;
        logic [27:0] wstep;
        set = '0;
        clr = '0;
        det_ok = 1'b0;
        det_code = 3'h0;
        tgt = 3'h0;
        good = 1'b0;
        nv = '0;
        ov = '0;
        wv = '0;
        wstep = '0;
        n = r;
        // Pin synchronisers
        n.sy1 = {optical_sync_in, digital_input_sync, wordclock_in};
        n.sy2 = r.sy1;
        n.sy3 = r.sy2;
        // Stand-alone: find which rate the reference runs at
        for (int i = 0; i < `SCS_RATE_NUM; i++)
        begin
            if (!det_ok && match(meas_per, 3'(i)))
            begin
                det_ok = 1'b1; // RL6
                det_code = 3'(i);
            end
        end
        tgt = r.ctrl[`SCS_CTRL_SA] ? det_code : ctrl_rate; // RL6
        good = meas_new && (r.ctrl[`SCS_CTRL_SA] ? det_ok : match(meas_per, ctrl_rate)); // RL13
        // Clocking state machine
        unique case (r.st)
            SCS_ST_MASTER:
            begin
                n.act_rate = ctrl_rate;
                n.qual = '0;
                if (sync_sel != SCS_SRC_LOCAL)
                begin
                    // Selected but not yet qualified
                    n.st = SCS_ST_FALLBACK; // RL4
                    set[`SCS_IRQ_FALLBACK] = 1'b1;
                end
            end
            SCS_ST_SLAVE:
            begin
                if (sync_sel == SCS_SRC_LOCAL)
                begin
                    n.st = SCS_ST_MASTER; // RL2
                end
                else if (meas_absent || (meas_new && !(good && tgt == r.act_rate)))
                begin
                    // Lost, invalid or off-rate: back to local at selected rate
                    n.st = SCS_ST_FALLBACK; // RL4
                    n.act_rate = ctrl_rate;
                    n.qual = '0;
                    set[`SCS_IRQ_FALLBACK] = 1'b1;
                end
            end
            SCS_ST_FALLBACK:
            begin
                n.act_rate = ctrl_rate; // RL4
                if (sync_sel == SCS_SRC_LOCAL)
                begin
                    n.st = SCS_ST_MASTER;
                end
                else if (meas_absent || (meas_new && !good))
                begin
                    n.qual = '0; // RL13
                end
                else if (good && r.qual == 4'(QUAL - 1))
                begin
                    // Reference qualified again: lock and resume audio
                    n.st = SCS_ST_SLAVE; // RL5
                    n.act_rate = tgt;
                    n.qual = '0;
                    set[`SCS_IRQ_LOCK] = 1'b1;
                    set[`SCS_IRQ_RATE_CHG] = tgt != ctrl_rate;
                end
                else if (good)
                begin
                    n.qual = r.qual + 4'h1;
                end
            end
        endcase
        // Main sample clock from the internal divider, or from the reference edge when slave
        nv = nco(r.nacc, rate_hz(n.act_rate)); // RL1
        n.nacc = nv[27:0];
        n.tick = (n.st == SCS_ST_SLAVE) ? sel_edge : nv[28]; // RL3
        // Indicator and audio gate
        if (n.st == SCS_ST_FALLBACK)
        begin
            if (r.bcnt == BW'(BLINK_CYC - 1))
            begin
                n.bcnt = '0;
                n.blink = !r.blink;
            end
            else
            begin
                n.bcnt = r.bcnt + BW'(1);
            end
        end
        else
        begin
            n.bcnt = '0;
            n.blink = 1'b1;
        end
        n.led = (n.st == SCS_ST_MASTER) || (n.st == SCS_ST_FALLBACK && n.blink); // RL2
        n.aen = n.st != SCS_ST_FALLBACK; // RL5
        // Converter placement; both at once is not a legal setting
        n.sin = r.ctrl[`SCS_CTRL_CONV] == SCS_CONV_IN; // RL8
        n.sout = r.ctrl[`SCS_CTRL_CONV] == SCS_CONV_OUT; // RL9
        ov = nco(r.oacc, rate_hz(r.ctrl[`SCS_CTRL_ORATE]));
        n.oacc = ov[27:0];
        if (!n.sout || osync_sel == SCS_SRC_LOCAL || osync_sel == SCS_SRC_OPTIC)
        begin
            n.olock = 1'b0;
            n.oqual = '0;
        end
        else if (omeas_absent || (omeas_new && !match(omeas_per, r.ctrl[`SCS_CTRL_ORATE])))
        begin
            set[`SCS_IRQ_OUT_LOST] = r.olock;
            n.olock = 1'b0;
            n.oqual = '0;
        end
        else if (omeas_new && !r.olock)
        begin
            n.olock = r.oqual == 4'(QUAL - 1); // RL9
            n.oqual = r.oqual + 4'h1;
        end
        // Without an output converter every channel shares one clock
        if (!n.sout)
        begin
            n.otick = n.tick; // RL7
        end
        else
        begin
            n.otick = n.olock ? out_edge : ov[28]; // RL9
        end
        // Word clock output toggles at twice the chosen frequency
        case (scs_wcm_t'(r.ctrl[`SCS_CTRL_WCM]))
            SCS_WCM_X256: wstep = rate_hz(n.act_rate) << `SCS_WC_SUPER_SHIFT; // RL10
            // Codes 6 and 7 run at 48 kHz, so they belong to the 48k family
            SCS_WCM_BASE: wstep = ((n.act_rate[0] || n.act_rate[2:1] == 2'b11)
                ? `SCS_RATE1_HZ : `SCS_RATE0_HZ) << `SCS_WC_PLAIN_SHIFT; // RL11
            default: wstep = rate_hz(n.act_rate) << `SCS_WC_PLAIN_SHIFT; // RL10
        endcase
        wv = nco(r.wacc, wstep);
        n.wacc = wv[27:0];
        n.wclk = r.wclk ^ wv[28];
        // APB: setup cycle prepares the answer, access cycle completes
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        if (psel && !penable)
        begin
            n.pready = 1'b1;
            n.prdata = '0;
            case (paddr)
                `SCS_ADDR_CTRL: n.prdata = 32'(r.ctrl);
                `SCS_ADDR_STATUS: n.prdata = 32'({r.olock, meas_absent, r.act_rate, r.st});
                `SCS_ADDR_IRQ_STAT: n.prdata = 32'(r.istat);
                `SCS_ADDR_IRQ_MASK: n.prdata = 32'(r.imask);
                `SCS_ADDR_PERIOD: n.prdata = 32'(meas_per);
                default: n.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && r.pready && pwrite && !r.pslverr)
        begin
            case (paddr)
                `SCS_ADDR_CTRL: n.ctrl = pwdata[`SCS_CTRL_W-1:0];
                `SCS_ADDR_IRQ_MASK: n.imask = pwdata[`SCS_IRQ_W-1:0];
                `SCS_ADDR_IRQ_STAT: clr = pwdata[`SCS_IRQ_W-1:0];
                default: clr = '0;
            endcase
        end
        // Sticky events: a new event wins over a clear
        n.istat = (r.istat & ~clr) | set;
        n.irq = |(n.istat & n.imask);
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            r <= '{ctrl: `SCS_CTRL_RST, st: SCS_ST_MASTER, led: 1'b1, aen: 1'b1,
                blink: 1'b1, default: '0};
        end
        else
        begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign sample_tick = r.tick;
    assign out_sample_tick = r.otick;
    assign wordclock_out = r.wclk;
    assign master_led = r.led;
    assign audio_enable = r.aen;
    assign src_in_active = r.sin;
    assign src_out_active = r.sout;
    assign irq = r.irq;

    // Checks on the clocking behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    master_led_on_a: assert property (r.st == SCS_ST_MASTER |-> master_led && audio_enable) // RL2
        else $error("master state without steady indicator");
    local_is_master_a: assert property (sync_sel == SCS_SRC_LOCAL |=> r.st == SCS_ST_MASTER) // RL2
        else $error("local selection did not give master");
    slave_led_off_a: assert property (r.st == SCS_ST_SLAVE |-> !master_led && audio_enable) // RL3
        else $error("slave state with indicator lit");
    absent_fallback_a: assert property ( // RL4
        (r.st == SCS_ST_SLAVE && meas_absent && sync_sel != SCS_SRC_LOCAL)
        |=> r.st == SCS_ST_FALLBACK)
        else $error("absent reference kept slave state");
    fallback_rate_a: assert property ( // RL4
        $past(r.st) == SCS_ST_FALLBACK && r.st == SCS_ST_FALLBACK
        |-> r.act_rate == $past(ctrl_rate))
        else $error("fallback not at selected rate");
    fallback_mute_a: assert property (r.st == SCS_ST_FALLBACK |-> !audio_enable) // RL5
        else $error("audio enabled during fallback");
    relock_qual_a: assert property ( // RL13
        $rose(r.st == SCS_ST_SLAVE) |-> $past(r.qual) == 4'(QUAL - 1))
        else $error("locked without full qualification");
    common_tick_a: assert property (!src_out_active |-> out_sample_tick == sample_tick) // RL7
        else $error("output clock differs without converter");
    out_lock_conv_a: assert property (r.olock |-> src_out_active && !src_in_active) // RL9
        else $error("output lock without output converter");

    lock_seen_c: cover property ($rose(r.st == SCS_ST_SLAVE));
    fallback_seen_c: cover property (r.st == SCS_ST_SLAVE ##1 r.st == SCS_ST_FALLBACK);
    out_lock_seen_c: cover property ($rose(r.olock));
    irq_seen_c: cover property ($rose(irq));
endmodule

//--- test_scs_sync_top.sv
// Self-checking bench for the sample clock sync selector
`timescale 1ns/100ps
`include "scs_map.svh"
module test_scs_sync_top;
    import scs_pkg::*;
    // 192 kHz reference period in system clocks
    localparam int PER = 1041;
    // Clock, reset and bus
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    // References and block outputs
    logic wc_run, di_run, wordclock_in, digital_input_sync;
    logic [15:0] wc_per, di_per;
    logic sample_tick, out_sample_tick, wordclock_out, master_led, audio_enable;
    logic src_in_active, src_out_active, irq;
    // Counters
    int err_count, compares, e, n_wc, n_st, n_ot, n_off, n_tg;

    // Block under test with short blink and absence times
    scs_sync_top #(.BLINK_CYC(16), .TIMEOUT_CYC(1500), .QUAL(8)) scs_sync_top_i (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wordclock_in(wordclock_in),
        .digital_input_sync(digital_input_sync), .optical_sync_in(digital_input_sync),
        .sample_tick(sample_tick), .out_sample_tick(out_sample_tick),
        .wordclock_out(wordclock_out), .master_led(master_led),
        .audio_enable(audio_enable), .src_in_active(src_in_active),
        .src_out_active(src_out_active), .irq(irq));
    // Word clock and digital input references; the optical pin shares the latter
    scs_ref_src wc_src_i (.run(wc_run), .period(wc_per), .ref_clk(wordclock_in));
    scs_ref_src di_src_i (.run(di_run), .period(di_per), .ref_clk(digital_input_sync));

    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // The slave answers in the first access cycle
        chk(n, 1, "pready");
    endtask

    // Read and compare masked bits
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                       input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, x, what);
    endtask

    // Wait for the audio enable level, bounded
    task automatic wt(input logic v);
        int n;
        n = 0;
        while (audio_enable !== v && n < 16000)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk(n < 16000, 1, "wait");
    endtask

    // Count output events over a window of cycles
    task automatic cnt(input int cyc);
        logic pw, pl;
        {n_wc, n_st, n_ot, n_off, n_tg} = '0;
        pw = wordclock_out;
        pl = master_led;
        repeat (cyc)
        begin
            @(posedge sys_clk);
            n_wc += (wordclock_out === 1'b1 && pw === 1'b0);
            n_st += (sample_tick === 1'b1);
            n_ot += (out_sample_tick === 1'b1);
            n_off += (master_led !== 1'b1);
            n_tg += (master_led !== pl);
            pw = wordclock_out;
            pl = master_led;
        end
    endtask

    // Expected events in an 8334 cycle window
    function automatic int edges(longint hz);
        return int'(hz * 8334 / `SCS_CLK_HZ);
    endfunction

    // Tolerance test
    function automatic logic near(int got, int exp, int tol);
        return got >= exp - tol && got <= exp + tol;
    endfunction

    // Verdict and end of run
    task automatic test_done;
        $display("Counts: %0d mismatches, %0d compares", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #475000;
        err_count++;
        $display("Error at %0t: timeout", $time);
        test_done;
    end

    // Main sequence
    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, wc_run, di_run} = '0;
        {err_count, compares} = '0;
        wc_per = 16'(PER);
        di_per = 16'(PER);
        void'($urandom(12));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset defaults and registers
        chk(master_led, 1, "led");
        chk(audio_enable, 1, "audio");
        rdc(`SCS_ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl");
        rdc(`SCS_ADDR_STATUS, 32'h0000_0007, 32'h0000_0001, "master");
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(err, 1, "slverr");
        r = $urandom;
        apb(1'b1, `SCS_ADDR_IRQ_MASK, r);
        rdc(`SCS_ADDR_IRQ_MASK, 32'hFFFF_FFFF, r & 32'h0000_000F, "mask");
        // Word clock modes at 192 kHz, local reference
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, `SCS_ADDR_CTRL, 32'(5 + (m << 6)));
            cnt(100);
            cnt(8334);
            e = edges(m == 2 ? `SCS_RATE1_HZ : `SCS_RATE5_HZ * (m == 1 ? 256 : 1));
            chk(near(n_wc, e, 2), 1, "wclk");
            chk(near(n_st, edges(`SCS_RATE5_HZ), 1), 1, "tick");
            chk(n_off, 0, "steady");
            chk(n_ot, n_st, "common");
        end
        // Input converter flag
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_0100);
        cnt(3);
        chk(src_in_active, 1, "src in");
        chk(src_out_active, 0, "src out");
        // Word clock sync at 192 kHz, slightly off-nominal
        wc_per <= 16'(PER - 4 + $urandom % 9);
        wc_run <= 1'b1;
        apb(1'b1, `SCS_ADDR_IRQ_MASK, 32'h0000_0001);
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_000D);
        cnt(3);
        chk(audio_enable, 0, "mute");
        cnt(64);
        chk(n_tg >= 2, 1, "blink");
        wt(1'b1);
        cnt(3);
        chk(master_led, 0, "slave led");
        rdc(`SCS_ADDR_STATUS, 32'h0000_0007, 32'h0000_0002, "slave");
        chk(irq, 1, "irq");
        apb(1'b1, `SCS_ADDR_IRQ_STAT, 32'h0000_0003);
        rdc(`SCS_ADDR_IRQ_STAT, 32'h0000_0003, 32'h0000_0000, "w1c");
        chk(irq, 0, "irq clr");
        // Off-frequency reference, then absent, then back
        wc_per <= 16'(PER + 200);
        wt(1'b0);
        rdc(`SCS_ADDR_STATUS, 32'h0000_0007, 32'h0000_0004, "fallback");
        rdc(`SCS_ADDR_IRQ_STAT, 32'h0000_0002, 32'h0000_0002, "fb irq");
        wc_run <= 1'b0;
        cnt(1700);
        rdc(`SCS_ADDR_STATUS, 32'h0000_0040, 32'h0000_0040, "absent");
        wc_per <= 16'(PER);
        wc_run <= 1'b1;
        wt(1'b1);
        rdc(`SCS_ADDR_STATUS, 32'h0000_0007, 32'h0000_0002, "relock");
        // Stand-alone at 44.1k setting via optical, output converter on digital input
        di_run <= 1'b1;
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_5638);
        wt(1'b0);
        wt(1'b1);
        rdc(`SCS_ADDR_STATUS, 32'h0000_003F, 32'h0000_002A, "follow");
        rdc(`SCS_ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004, "rate irq");
        cnt(2000);
        chk(src_out_active, 1, "src out");
        rdc(`SCS_ADDR_STATUS, 32'h0000_0080, 32'h0000_0080, "out lock");
        cnt(8334);
        chk(near(n_ot, edges(`SCS_RATE5_HZ), 1), 1, "out tick");
        test_done;
    end
endmodule
